/* File: rtl/adc_seq_map.vh */
// constants for the converter control and sequencer block
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH

// timing
`define CLK_PERIOD_NS   4
`define CONV_TIME_NS    1400
`define CONV_CYCLES     ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define START_RELEASE_NS 400

// mode select codes {mode_select_hi, mode_select_lo}
`define MODE_DIRECT     2'h0
`define MODE_SCAN       2'h1
`define MODE_PROGRAM    2'h2
`define MODE_RUN        2'h3

// sequencer memory
`define SEQ_DEPTH       16
`define SEQ_AW          4
`define SEQ_WIDTH       7

// status word fields
`define ST_PAIR         6
`define ST_ADDR_HI      5
`define ST_ADDR_LO      3
`define ST_POL          2
`define ST_GAIN         1
`define ST_END          0

// reset values
`define RESULT_RESET    12'h000
`define PTR_RESET       4'h0
`define SCAN_RESET      3'h0

`endif

/* File: rtl/pin_sync.v */
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module pin_sync #(
  parameter WIDTH = 12
) (
  // clock and reset
  input  wire             mclk,
  input  wire             rst_b,
  // pins and synchronised copies
  input  wire [WIDTH-1:0] pins,
  output wire [WIDTH-1:0] pins_sync
);

  genvar i;
  // one pair of flops per bit; reset high, the idle level of the strobes
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg stage1;
      reg stage2;
      always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          stage1 <= 1'h1;
          stage2 <= 1'h1;
        end else begin
          stage1 <= pins[i];
          stage2 <= stage1;
        end
      end
      assign pins_sync[i] = stage2;
    end
  endgenerate

endmodule

/* File: rtl/seq_memory.v */
// sequencer memory, one write port and a registered read port
`timescale 1ns/10ps
module seq_memory #(
  parameter WIDTH = 7,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             mclk,
  input  wire             rst_b,
  // write port
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  // read port
  input  wire [AW-1:0]    rd_addr,
  output reg  [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // contents survive mode changes, so the array carries no reset
  always @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data one cycle after the address
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= {WIDTH{1'b0}};
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

/* File: rtl/adc_conversion_mux_sequencer.v */
// conversion handshake, mux address generation and sequencer control
// Functional notes
// - start on start pin low while selected
// - ignore starts while converting
// - busy low for the whole conversion
// - select and read low keep outputs driven
// - outputs float until read strobe low
// - read tied to start shows previous result
// - each read low starts next conversion
// - direct mode takes address and span pins
// - config pins transparent while write low, held
// - scan mode counts channels, ignores address pins
// - single-ended scan covers eight channels
// - differential scan covers four adjacent pairs
// - counter steps one or two per conversion
// - low mode select change clears scan counter
// - used address and pair flag shown out
// - sixteen locations, six bits plus end flag
// - readback gives 7-bit status word
// - busy low, no conversions while programming
// - either mode select change resets pointer
// - write strobe rise stores and advances
// - last write marks end; wraps after sixteen
// - read strobe drives word, rise advances
// - end flag reads one at last location
// - run mode uses location then advances
`timescale 1ns/10ps
`include "adc_seq_map.vh"
module adc_conversion_mux_sequencer #(
  parameter RESULT_WIDTH = 12,
  parameter CONV_CYCLES  = `CONV_CYCLES,
  parameter CNT_WIDTH    = 12
) (
  // clock and reset
  input  wire                    mclk,
  input  wire                    rst_b,
  // host control pins
  input  wire                    chip_select_n,
  input  wire                    read_n,
  input  wire                    write_n,
  input  wire                    conversion_start_n,
  input  wire                    mode_select_hi,
  input  wire                    mode_select_lo,
  // configuration pins
  input  wire                    differential_select,
  input  wire                    mux_address_in_2,
  input  wire                    mux_address_in_1,
  input  wire                    mux_address_in_0,
  input  wire                    gain_range_select,
  input  wire                    polarity_select,
  // result from the analog core
  input  wire [RESULT_WIDTH-1:0] core_result,
  // to the analog core
  output reg                     sample_start,
  output reg  [2:0]              mux_channel,
  output reg                     mux_differential,
  output reg                     mux_gain,
  output reg                     mux_polarity,
  // host outputs
  output reg                     busy_n,
  output reg  [RESULT_WIDTH-1:0] data_out,
  output reg  [RESULT_WIDTH-1:0] data_oe,
  output reg                     address_out_bit2,
  output reg                     address_out_bit1,
  output reg                     address_out_bit0,
  output reg                     differential_out_flag,
  output reg                     address_oe
);
  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_DONE = 2'h2;
  localparam integer CONV_LAST = CONV_CYCLES - 1;
  wire [11:0]              pins_sync;
  wire                     cs_s;
  wire                     rd_s;
  wire                     wr_s;
  wire                     cstart_s;
  wire [1:0]               mode;
  wire [5:0]               cfg_pins;
  reg  [1:0]               mode_prev;
  reg                      cstart_prev;
  reg                      rd_prev;
  reg                      wr_prev;
  reg  [1:0]               state;
  reg  [1:0]               next_state;
  reg  [CNT_WIDTH-1:0]     conv_cnt;
  reg  [5:0]               cfg_latch;
  reg  [5:0]               sel_cfg;
  reg  [5:0]               conv_cfg;
  reg  [1:0]               conv_mode;
  reg                      conv_wrap;
  reg  [RESULT_WIDTH-1:0]  result;
  reg  [3:0]               addr_held;
  reg  [2:0]               scan_cnt;
  reg  [`SEQ_AW-1:0]       seq_ptr;
  reg  [5:0]               last_cfg;
  reg                      fix_pending;
  reg  [`SEQ_AW-1:0]       fix_addr;
  reg  [5:0]               fix_cfg;
  reg                      mem_wr_en;
  reg  [`SEQ_AW-1:0]       mem_wr_addr;
  reg  [`SEQ_WIDTH-1:0]    mem_wr_data;
  wire [`SEQ_WIDTH-1:0]    mem_rdata;
  wire                     mode_change;
  wire                     lo_change;
  wire                     cstart_fall;
  wire                     rd_rise;
  wire                     wr_rise;
  wire                     programming;
  wire                     start_ok;
  wire                     conv_end;
  wire                     seq_write;
  wire                     seq_read_step;
  wire                     rd_active;
  // every pin crosses two flops before any logic looks at it
  pin_sync #(
    .WIDTH (12)
  ) u_pin_sync (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .pins      ({chip_select_n, read_n, write_n, conversion_start_n,
                 mode_select_hi, mode_select_lo, differential_select,
                 mux_address_in_2, mux_address_in_1, mux_address_in_0,
                 polarity_select, gain_range_select}),
    .pins_sync (pins_sync)
  );
  assign cs_s     = pins_sync[11];
  assign rd_s     = pins_sync[10];
  assign wr_s     = pins_sync[9];
  assign cstart_s = pins_sync[8];
  assign mode     = pins_sync[7:6];
  assign cfg_pins = pins_sync[5:0];

  // edge detection on synchronised pins
  assign mode_change = (mode != mode_prev);
  assign lo_change   = (mode[0] != mode_prev[0]);
  assign cstart_fall = cstart_prev & ~cstart_s;
  assign rd_rise     = ~rd_prev & rd_s;
  assign wr_rise     = ~wr_prev & wr_s;
  assign programming = (mode == `MODE_PROGRAM);
  assign rd_active   = ~cs_s & ~rd_s;
  // a start is only taken when idle and selected
  assign start_ok = (state == ST_IDLE) & cstart_fall & ~cs_s & ~programming;
  assign conv_end = (state == ST_CONV) & (conv_cnt == CONV_LAST[CNT_WIDTH-1:0]);

  // program and readback strobes, the other strobe held high
  assign seq_write     = programming & ~mode_change & wr_rise & rd_s;
  assign seq_read_step = programming & ~mode_change & rd_rise & wr_s;

  // history starts at the synced reset levels, so reset makes no edge
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mode_prev   <= 2'h3;
      cstart_prev <= 1'h1;
      rd_prev     <= 1'h1;
      wr_prev     <= 1'h1;
    end else begin
      mode_prev   <= mode;
      cstart_prev <= cstart_s;
      rd_prev     <= rd_s;
      wr_prev     <= wr_s;
    end
  end

  // config pins follow while write is low, hold while it is high
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_latch <= 6'h00;
    end else if (!wr_s) begin
      cfg_latch <= cfg_pins;
    end
  end

  // configuration used for a conversion, chosen by mode
  always @* begin
    sel_cfg = cfg_latch;
    if (mode == `MODE_SCAN) begin
      sel_cfg[4:2] = scan_cnt;
    end else if (mode == `MODE_RUN) begin
      sel_cfg = mem_rdata[`SEQ_WIDTH-1:1];
    end
  end

  // conversion state machine
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_ok) begin
          next_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (conv_end) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        // one settle cycle lets the memory read catch up with the pointer
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= ST_IDLE;
      conv_cnt  <= {CNT_WIDTH{1'b0}};
      conv_cfg  <= 6'h00;
      conv_mode <= `MODE_DIRECT;
      conv_wrap <= 1'h0;
    end else begin
      state <= next_state;
      if (start_ok) begin
        conv_cnt  <= {CNT_WIDTH{1'b0}};
        conv_cfg  <= sel_cfg;
        conv_mode <= mode;
        conv_wrap <= mem_rdata[`ST_END];
      end else if (state == ST_CONV) begin
        conv_cnt <= conv_cnt + 1'b1;
      end
    end
  end

  // drive the analog core at the start of each conversion
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sample_start     <= 1'h0;
      mux_channel      <= 3'h0;
      mux_differential <= 1'h0;
      mux_gain         <= 1'h0;
      mux_polarity     <= 1'h0;
    end else begin
      sample_start <= start_ok;
      if (start_ok) begin
        mux_differential <= sel_cfg[5];
        mux_channel      <= sel_cfg[4:2];
        mux_polarity     <= sel_cfg[1];
        mux_gain         <= sel_cfg[0];
      end
    end
  end

  // busy low while converting and throughout program or readback
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      busy_n <= 1'h1;
    end else begin
      busy_n <= (next_state == ST_IDLE) & ~programming;
    end
  end

  // result and used address captured together at the end
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      result    <= `RESULT_RESET;
      addr_held <= 4'h0;
    end else if (conv_end) begin
      result    <= core_result;
      addr_held <= conv_cfg[5:2];
    end
  end

  // scan counter; a low-select change wins over an advance
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      scan_cnt <= `SCAN_RESET;
    end else if (lo_change) begin
      scan_cnt <= `SCAN_RESET;
    end else if (conv_end && conv_mode == `MODE_SCAN) begin
      scan_cnt <= conv_cfg[5] ? scan_cnt + 3'h2 : scan_cnt + 3'h1;
    end
  end

  // sequencer pointer; 4 bits so sixteen steps wrap to zero
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      seq_ptr <= `PTR_RESET;
    end else if (mode_change) begin
      seq_ptr <= `PTR_RESET;
    end else if (seq_write || seq_read_step) begin
      seq_ptr <= seq_ptr + 1'b1;
    end else if (conv_end && conv_mode == `MODE_RUN) begin
      seq_ptr <= conv_wrap ? `PTR_RESET : seq_ptr + 1'b1;
    end
  end

  // each write lands with its end flag set, then, unless it went to location 0, the previous
  // location is rewritten with the flag cleared one cycle later
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      last_cfg    <= 6'h00;
      fix_pending <= 1'h0;
      fix_addr    <= `PTR_RESET;
      fix_cfg     <= 6'h00;
    end else begin
      fix_pending <= seq_write & (seq_ptr != `PTR_RESET);
      if (seq_write) begin
        last_cfg <= cfg_latch;
        fix_addr <= seq_ptr - 1'b1;
        fix_cfg  <= last_cfg;
      end
    end
  end

  // single write port shared by store and fix-up
  always @* begin
    mem_wr_en   = 1'b0;
    mem_wr_addr = seq_ptr;
    mem_wr_data = {cfg_latch, 1'b1};
    if (seq_write) begin
      mem_wr_en = 1'b1;
    end else if (fix_pending) begin
      mem_wr_en   = 1'b1;
      mem_wr_addr = fix_addr;
      mem_wr_data = {fix_cfg, 1'b0};
    end
  end

  seq_memory #(
    .WIDTH (`SEQ_WIDTH),
    .DEPTH (`SEQ_DEPTH),
    .AW    (`SEQ_AW)
  ) u_seq_memory (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .wr_en   (mem_wr_en),
    .wr_addr (mem_wr_addr),
    .wr_data (mem_wr_data),
    .rd_addr (seq_ptr),
    .rd_data (mem_rdata)
  );
  // output pins; readback reuses the top data bits and address pins
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      data_out              <= `RESULT_RESET;
      data_oe               <= {RESULT_WIDTH{1'b0}};
      address_out_bit2      <= 1'h0;
      address_out_bit1      <= 1'h0;
      address_out_bit0      <= 1'h0;
      differential_out_flag <= 1'h0;
      address_oe            <= 1'h0;
    end else if (programming) begin
      data_out <= {mem_rdata[`ST_POL:`ST_END], result[RESULT_WIDTH-4:0]};
      data_oe  <= {{3{rd_active}}, {(RESULT_WIDTH-3){1'b0}}};
      differential_out_flag <= mem_rdata[`ST_PAIR];
      address_out_bit2      <= mem_rdata[`ST_ADDR_HI];
      address_out_bit1      <= mem_rdata[`ST_ADDR_HI-1];
      address_out_bit0      <= mem_rdata[`ST_ADDR_LO];
      address_oe            <= rd_active;
    end else begin
      // outputs show the last result until the next one ends
      data_out <= result;
      data_oe  <= {RESULT_WIDTH{rd_active}};
      differential_out_flag <= addr_held[3];
      address_out_bit2      <= addr_held[2];
      address_out_bit1      <= addr_held[1];
      address_out_bit0      <= addr_held[0];
      address_oe            <= rd_active;
    end
  end

endmodule

/* File: bench/adc_conversion_mux_sequencer_assertions.sv */
// port checker for the converter control and sequencer block
`timescale 1ns/10ps
module adc_seq_checker #(
  parameter RESULT_WIDTH = 12,
  parameter CONV_CYCLES  = 350
) (
  // clock and reset
  input wire                    mclk,
  input wire                    rst_b,
  // host pins
  input wire                    chip_select_n,
  input wire                    read_n,
  input wire                    conversion_start_n,
  input wire                    mode_select_hi,
  input wire                    mode_select_lo,
  // device outputs
  input wire                    sample_start,
  input wire [2:0]              mux_channel,
  input wire                    mux_differential,
  input wire                    busy_n,
  input wire [RESULT_WIDTH-1:0] data_oe,
  input wire                    address_out_bit2,
  input wire                    address_out_bit1,
  input wire                    address_out_bit0,
  input wire                    differential_out_flag,
  input wire                    address_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // raw pin view; the pins pass two sync flops first, hence the long runs
  wire       prog = mode_select_hi & ~mode_select_lo;
  wire [3:0] apins = {differential_out_flag, address_out_bit2, address_out_bit1,
                      address_out_bit0};
  // cycles since the last take, saturating so it hits each figure once
  reg  [15:0] since;
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      since <= 16'h0000;
    else if (sample_start)
      since <= 16'h0001;
    else if (since != 16'h0000 && since != 16'hFFFF)
      since <= since + 16'h0001;
  end
  sequence s_taken; sample_start && !busy_n; endsequence
  sequence s_held; (!sample_start && !busy_n) [*8]; endsequence
  property p_take_cause; sample_start |-> $past(!conversion_start_n && !chip_select_n, 2);
  endproperty
  property p_busy_span; s_taken |=> s_held; endproperty
  property p_busy_rel; (since == CONV_CYCLES + 1) |-> $rose(busy_n); endproperty
  property p_addr_out; (since == CONV_CYCLES + 1) |-> apins == {mux_differential, mux_channel};
  endproperty
  property p_prog_busy; prog [*6] |-> !busy_n; endproperty
  property p_prog_idle; prog [*6] |-> !sample_start; endproperty
  property p_read_drive; (!chip_select_n && !read_n && !prog) [*4] |-> (&data_oe) && address_oe;
  endproperty
  property p_read_float; (chip_select_n || read_n) [*4] |-> data_oe == '0 && !address_oe;
  endproperty
  a_take_cause: assert property (p_take_cause) else $error("take without start");
  a_busy_span: assert property (p_busy_span) else $error("busy window broken");
  a_busy_rel: assert property (p_busy_rel) else $error("busy length wrong");
  a_addr_out: assert property (p_addr_out) else $error("address out wrong");
  a_prog_busy: assert property (p_prog_busy) else $error("busy high in program");
  a_prog_idle: assert property (p_prog_idle) else $error("start in program");
  a_read_drive: assert property (p_read_drive) else $error("outputs not driven");
  a_read_float: assert property (p_read_float) else $error("outputs not floating");
endmodule

bind adc_conversion_mux_sequencer adc_seq_checker #(
  .RESULT_WIDTH(RESULT_WIDTH),
  .CONV_CYCLES (CONV_CYCLES)
) chk_inst (
  .mclk(mclk), .rst_b(rst_b), .chip_select_n(chip_select_n), .read_n(read_n),
  .conversion_start_n(conversion_start_n), .mode_select_hi(mode_select_hi),
  .mode_select_lo(mode_select_lo), .sample_start(sample_start), .mux_channel(mux_channel),
  .mux_differential(mux_differential), .busy_n(busy_n), .data_oe(data_oe),
  .address_out_bit2(address_out_bit2), .address_out_bit1(address_out_bit1),
  .address_out_bit0(address_out_bit0), .differential_out_flag(differential_out_flag),
  .address_oe(address_oe)
);

/* File: bench/host_model.sv */
// host processor model driving the control pins of the converter
`timescale 1ns/10ps
module host_model (
  // clock
  input  wire        mclk,
  // control pins
  output logic       chip_select_n,
  output logic       read_n,
  output logic       write_n,
  output logic       conversion_start_n,
  // device outputs
  input  wire        busy_n,
  input  wire [11:0] data_out,
  input  wire [11:0] data_oe,
  input  wire [3:0]  addr_out,
  input  wire        addr_oe
);
  // an undriven pin reads as the inverse of the last value shown
  wire [11:0] data_bus = data_out ~^ data_oe;
  wire [3:0]  addr_bus = addr_out ~^ {4{addr_oe}};
  // selected, config transparent, nothing pending
  initial begin
    chip_select_n = 1'b0;
    read_n = 1'b1;
    write_n = 1'b0;
    conversion_start_n = 1'b1;
  end
  // start pulse; with tied set, read moves with the start pin
  task automatic start_conv(input bit tied, output logic [11:0] early, output logic [11:0] late);
    int n;
    @(posedge mclk);
    conversion_start_n <= 1'b0;
    if (tied)
      read_n <= 1'b0;
    repeat (6) @(posedge mclk);
    if (!tied)
      conversion_start_n <= 1'b1; // well inside 400 ns
    @(negedge mclk);
    early = data_bus;
    n = 0;
    while (busy_n !== 1'b1 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    late = data_bus; // captured as busy rises
    @(posedge mclk);
    conversion_start_n <= 1'b1; // only after busy rose
    if (tied)
      read_n <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask
  // one program write, read held high
  task automatic write_strobe();
    @(posedge mclk);
    write_n <= 1'b0;
    repeat (4) @(posedge mclk);
    write_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
  // one readback strobe
  task automatic read_word(output logic [6:0] w);
    @(posedge mclk);
    read_n <= 1'b0;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    w = {addr_bus, data_bus[11:9]};
    @(posedge mclk);
    read_n <= 1'b1;
    repeat (5) @(posedge mclk);
  endtask
endmodule

/* File: bench/tb.sv */
// self-checking bench for the converter control and sequencer block
`timescale 1ns/10ps
module tb;
  localparam int CONV = 8;
  // stimulus
  logic        mclk;
  logic        rst_b;
  logic        mode_select_hi;
  logic        mode_select_lo;
  logic [5:0]  cfg;
  logic [11:0] core_result;
  // pins and outputs
  wire         chip_select_n, read_n, write_n, conversion_start_n;
  wire         sample_start, mux_differential, mux_gain, mux_polarity, busy_n, address_oe;
  wire [2:0]   mux_channel;
  wire [11:0]  data_out, data_oe;
  wire         address_out_bit2, address_out_bit1, address_out_bit0, differential_out_flag;
  wire [3:0]   addr_out = {differential_out_flag, address_out_bit2, address_out_bit1,
                           address_out_bit0};
  wire [5:0]   mux_cfg = {mux_differential, mux_channel, mux_polarity, mux_gain};
  // bench state
  int          n_fail, checked, seed, cycles, n_starts, n, nw;
  logic [11:0] early, late, prev;
  logic [5:0]  exp_cfg;
  logic [5:0]  mem [16];
  logic [6:0]  w;
  logic [2:0]  ch;
  bit          d;

  adc_conversion_mux_sequencer #(.CONV_CYCLES(CONV)) u_adc_conversion_mux_sequencer (
    .mclk(mclk), .rst_b(rst_b), .chip_select_n(chip_select_n), .read_n(read_n),
    .write_n(write_n), .conversion_start_n(conversion_start_n),
    .mode_select_hi(mode_select_hi), .mode_select_lo(mode_select_lo),
    .differential_select(cfg[5]), .mux_address_in_2(cfg[4]), .mux_address_in_1(cfg[3]),
    .mux_address_in_0(cfg[2]), .polarity_select(cfg[1]), .gain_range_select(cfg[0]),
    .core_result(core_result), .sample_start(sample_start), .mux_channel(mux_channel),
    .mux_differential(mux_differential), .mux_gain(mux_gain), .mux_polarity(mux_polarity),
    .busy_n(busy_n), .data_out(data_out), .data_oe(data_oe),
    .address_out_bit2(address_out_bit2), .address_out_bit1(address_out_bit1),
    .address_out_bit0(address_out_bit0), .differential_out_flag(differential_out_flag),
    .address_oe(address_oe)
  );
  host_model host (
    .mclk(mclk), .chip_select_n(chip_select_n), .read_n(read_n), .write_n(write_n),
    .conversion_start_n(conversion_start_n), .busy_n(busy_n), .data_out(data_out),
    .data_oe(data_oe), .addr_out(addr_out), .addr_oe(address_oe)
  );
  // 250 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // take counter and hang guard
  always @(posedge mclk) begin
    cycles++;
    if (sample_start === 1'b1)
      n_starts++;
    if (cycles == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  function automatic logic [2:0] scan_step(input logic [2:0] c, input bit dd);
    return c + (dd ? 3'h2 : 3'h1);
  endfunction
  function automatic logic [6:0] status_word(input logic [5:0] c, input bit fin);
    return {c, fin};
  endfunction
  // main sequence
  initial begin
    seed = 30652;
    rst_b = 1'b0;
    mode_select_hi = 1'b0;
    mode_select_lo = 1'b0;
    cfg = 6'h00;
    core_result = 12'h000;
    prev = 12'h000;
    tick(16);
    rst_b <= 1'b1;
    tick(4);
    // direct mode: odd passes tie read to start and latch config under write
    for (int i = 0; i < 6; i++) begin
      cfg <= 6'($random(seed));
      core_result <= 12'($random(seed));
      if (!i[0])
        host.read_n <= 1'b0;
      tick(3);
      exp_cfg = cfg;
      if (i[0]) begin
        host.write_n <= 1'b1;
        tick(4);
        cfg <= ~cfg;
      end
      host.start_conv(i[0], early, late);
      chk(16'(mux_cfg), 16'(exp_cfg));
      chk(16'(late), 16'(core_result));
      chk(16'(addr_out), 16'(exp_cfg[5:2]));
      if (i[0])
        chk(16'(early), 16'(prev));
      prev = core_result;
      host.write_n <= 1'b0;
    end
    // second fall while busy must be dropped, not queued
    n = n_starts;
    fork
      host.start_conv(1'b0, early, late);
      begin
        tick(9);
        host.conversion_start_n <= 1'b0;
        tick(3);
        host.conversion_start_n <= 1'b1;
      end
    join
    tick(10);
    chk(16'(n_starts - n), 16'h0001);
    host.read_n <= 1'b1;
    tick(6);
    @(negedge mclk);
    chk(16'(data_oe), 16'h0000);
    // scan mode with random single or paired steps, re-entered mid-run
    @(posedge mclk);
    mode_select_lo <= 1'b1;
    ch = 3'h0;
    for (int i = 0; i < 12; i++) begin
      if (i == 8) begin
        mode_select_lo <= 1'b0;
        tick(6);
        mode_select_lo <= 1'b1;
        ch = 3'h0;
      end
      d = 1'($random(seed));
      cfg <= {d, 5'($random(seed))};
      tick(4);
      host.start_conv(1'b1, early, late);
      chk(16'({mux_differential, mux_channel}), 16'({d, ch}));
      chk(16'(addr_out), 16'({d, ch}));
      ch = scan_step(ch, d);
    end
    // program a random-length sequence; starts refused meanwhile
    mode_select_hi <= 1'b1;
    mode_select_lo <= 1'b0;
    host.write_n <= 1'b1;
    tick(8);
    @(negedge mclk);
    chk(16'(busy_n), 16'h0000);
    n = n_starts;
    host.start_conv(1'b0, early, late);
    chk(16'(n_starts - n), 16'h0000);
    nw = 3 + int'({$random(seed)} % 14);
    for (int k = 0; k < nw; k++) begin
      cfg <= 6'($random(seed));
      tick(1);
      mem[k] = cfg;
      host.write_strobe();
    end
    // toggle the low select to rewind the pointer before reading
    mode_select_lo <= 1'b1;
    tick(6);
    mode_select_lo <= 1'b0;
    tick(6);
    for (int k = 0; k < 17; k++) begin
      host.read_word(w);
      if (k < nw)
        chk(16'(w), 16'(status_word(mem[k], k == nw - 1)));
    end
    chk(16'(w), 16'(status_word(mem[0], 1'b0)));
    // run the stored sequence past its end
    @(posedge mclk);
    mode_select_lo <= 1'b1;
    tick(8);
    for (int k = 0; k < nw + 3; k++) begin
      host.start_conv(1'b1, early, late);
      chk(16'(mux_cfg), 16'(mem[k % nw]));
      chk(16'(addr_out), 16'(mem[k % nw][5:2]));
    end
    give_verdict();
  end
endmodule
